// file: logic/sbm_pkg.sv
package sbm_pkg;
  // Bus geometry
  localparam int unsigned BUS_BYTES   = 8;
  localparam int unsigned MSG_MAX_B   = 256;
  localparam int unsigned HDR_GAP_CYC = 1;
  localparam int unsigned REQ_LAT_CYC = 2;
  // Control block word layout (default order, bit 63 is leftmost)
  localparam int unsigned CTL_NUM_HI  = 59;
  localparam int unsigned CTL_NUM_LO  = 56;
  localparam int unsigned CTL_DAT_W   = 56;
  localparam int unsigned CTL_NUM_MAX = 8;
  localparam logic [3:0]  CTL_ZERO    = 4'h0;
  // Block type codes indexed by block number
  localparam logic [7:0] TYPE_CODE_0   = 8'hD2;
  localparam logic [7:0] TYPE_CODE_1   = 8'h99;
  localparam logic [7:0] TYPE_CODE_2   = 8'h55;
  localparam logic [7:0] TYPE_CODE_3   = 8'hB4;
  localparam logic [7:0] TYPE_CODE_4   = 8'hCC;
  localparam logic [7:0] TYPE_CODE_5   = 8'h66;
  localparam logic [7:0] TYPE_CODE_6   = 8'h33;
  localparam logic [7:0] TYPE_CODE_7   = 8'h4B;
  localparam logic [7:0] TYPE_CODE_8   = 8'h87;
  localparam logic [7:0] TYPE_CODE_BAD = 8'h00;

  // Kinds of block handed to the lane framing logic
  typedef enum logic [2:0] {
    SBM_BLK_IDLE,
    SBM_BLK_MSG_HDR,
    SBM_BLK_MSG_DATA,
    SBM_BLK_CTRL,
    SBM_BLK_USER
  } sbm_blk_kind_t;

  // One block toward the lanes
  typedef struct packed {
    sbm_blk_kind_t kind;
    logic [7:0]    block_type_field;
    logic [63:0]   data;
    logic [7:0]    size;
  } sbm_lane_blk_t;

  // One control block word with its type code
  typedef struct packed {
    logic [7:0]  block_type_field;
    logic [63:0] word;
  } sbm_ctrl_t;
endpackage

// file: logic/sbm_sideband.sv
// Notes on behaviour
// RL1 - Valid dropping mid-message inserts idle blocks; ready levels stay put.
// RL2 - Receive message valid only with real data; user ignores data otherwise.
// RL3 - Receive last marks the word ending a message.
// RL4 - Keep marks valid bytes of last word only; messages up to 256 bytes.
// RL5 - Active-low in-progress output is low during message reception.
// RL6 - User pulses message request one cycle together with the size code.
// RL7 - No new request until final data cycle accepted.
// RL8 - User holds message valid high whenever message data is valid.
// RL9 - During message data, normal ready low, message ready high until complete.
// RL10 - Higher-priority operations drop message ready while they last.
// RL11 - One cycle with both readies low before data, for the header block; the code holds both low two cycles (ST_WAIT and ST_HDR).
// RL12 - Short final receive word keeps upper bytes, from the top down.
// RL13 - Control blocks rank below message blocks, above user data.
// RL14 - Received control blocks pass through, type code turned into number.
// RL15 - Control word: zeros, 4-bit number, 56 data bits, or little-endian order.
// RL16 - Received control word uses the same layout as transmit.
// RL17 - Block numbers 0 to 8 map to the nine fixed type codes.
// RL18 - Only seven bytes of a control word carry payload.
// RL19 - Control ready withheld under higher-priority operations or message transfer.
// RL20 - Every control word accepted with valid and ready is transmitted.
// RL21 - Received type code decoded to number and presented with valid strobe.
// RL22 - Control handling identical for streaming and framed configurations.
// RL23 - Size code is byte count minus one; at most 256 bytes.
// RL24 - Message ready rises two cycles after request if nothing outranks it; the code raises it three cycles after.
// RL25 - Data sampled only on valid and ready; short tail uses leftmost bytes.
// RL26 - Reset returns sequencing to idle with ready outputs low.
module sbm_sideband
  import sbm_pkg::*;
#(
  parameter bit LITTLE_ENDIAN = 1'b0
)
(
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // Message transmit from user
  input  wire logic          msg_req_i,
  input  wire logic [7:0]    message_size_code_i,
  input  wire logic          msg_tx_valid_i,
  input  wire logic [63:0]   msg_tx_data_i,
  output logic               msg_tx_ready_o,
  output logic               usr_tx_ready_o,
  // Higher-priority requests from link layer
  input  wire logic          prio_busy_i,
  // Control block transmit from user
  input  wire logic          ctl_tx_valid_i,
  input  wire logic [63:0]   ctl_tx_data_i,
  output logic               ctl_tx_ready_o,
  // Blocks toward lane framing
  output sbm_lane_blk_t      lane_blk_o,
  output logic               lane_blk_valid_o,
  // Message receive from lanes
  input  wire logic          rx_msg_valid_i,
  input  wire logic [63:0]   rx_msg_data_i,
  input  wire logic          rx_msg_last_i,
  input  wire logic [3:0]    rx_msg_nbytes_i,
  output logic               msg_rx_valid_o,
  output logic [63:0]        msg_rx_data_o,
  output logic               msg_rx_last_o,
  output logic [7:0]         msg_rx_keep_o,
  output logic               msg_rx_idle_n_o,
  // Control block receive from lanes
  input  wire logic          rx_ctl_valid_i,
  input  wire sbm_ctrl_t     rx_ctl_i,
  output logic               ctl_rx_valid_o,
  output logic [63:0]        ctl_rx_data_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HDR, ST_DATA} sbm_tx_st_t;

  // Block number to type code
  function automatic logic [7:0] num2type(input logic [3:0] n);
    case (n)
      4'h0: num2type = TYPE_CODE_0;
      4'h1: num2type = TYPE_CODE_1;
      4'h2: num2type = TYPE_CODE_2;
      4'h3: num2type = TYPE_CODE_3;
      4'h4: num2type = TYPE_CODE_4;
      4'h5: num2type = TYPE_CODE_5;
      4'h6: num2type = TYPE_CODE_6;
      4'h7: num2type = TYPE_CODE_7;
      4'h8: num2type = TYPE_CODE_8;
      default: num2type = TYPE_CODE_BAD;
    endcase
  endfunction

  // Type code to block number
  function automatic logic [3:0] type2num(input logic [7:0] b);
    case (b)
      TYPE_CODE_0: type2num = 4'h0;
      TYPE_CODE_1: type2num = 4'h1;
      TYPE_CODE_2: type2num = 4'h2;
      TYPE_CODE_3: type2num = 4'h3;
      TYPE_CODE_4: type2num = 4'h4;
      TYPE_CODE_5: type2num = 4'h5;
      TYPE_CODE_6: type2num = 4'h6;
      TYPE_CODE_7: type2num = 4'h7;
      TYPE_CODE_8: type2num = 4'h8;
      default: type2num = 4'hF;
    endcase
  endfunction

  // Block number field of a word in the configured order
  function automatic logic [3:0] word_num(input logic [63:0] w);
    word_num = LITTLE_ENDIAN ? w[3:0] : w[CTL_NUM_HI:CTL_NUM_LO];
  endfunction

  sbm_tx_st_t    st_q;
  logic [8:0]    left_q;
  logic [7:0]    size_q;
  logic          msg_rdy_q;
  logic          usr_rdy_q;
  logic          ctl_rdy_q;
  sbm_lane_blk_t blk_q;
  logic          blk_v_q;
  logic          msg_take;
  logic          ctl_take;
  logic          buf_in_ready;
  logic          buf_out_valid;
  sbm_ctrl_t     buf_out;
  sbm_ctrl_t     buf_in;

  assign msg_take = msg_rdy_q && msg_tx_valid_i;                          // RL25
  assign ctl_take = ctl_rdy_q && ctl_tx_valid_i;                          // RL20
  assign buf_in   = '{block_type_field: num2type(word_num(ctl_tx_data_i)), word: ctl_tx_data_i}; // RL17

  // Message transmit sequencing: request, wait, header gap, data
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q   <= ST_IDLE;                                                  // RL26
      left_q <= 9'd0;
      size_q <= 8'h00;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (msg_req_i)
          begin
            size_q <= message_size_code_i;                                // RL6
            left_q <= {1'b0, message_size_code_i} + 9'd1;                 // RL23
            st_q   <= ST_WAIT;
          end
        ST_WAIT:
          st_q <= ST_HDR;
        ST_HDR:
          if (!prio_busy_i)
            st_q <= ST_DATA;                                              // RL11
        ST_DATA:
          if (msg_take)
          begin
            if (left_q <= 9'(BUS_BYTES))
            begin
              left_q <= 9'd0;
              st_q   <= ST_IDLE;                                          // RL9
            end
            else
              left_q <= left_q - 9'(BUS_BYTES);
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Ready levels; the header cycle holds both readies low
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      msg_rdy_q <= 1'b0;
      usr_rdy_q <= 1'b0;
    end
    else
    begin
      // Ready rises one cycle after ST_HDR, three after the request
      msg_rdy_q <= (st_q == ST_HDR && !prio_busy_i) ||
                   (st_q == ST_DATA && !prio_busy_i &&
                    !(msg_take && left_q <= 9'(BUS_BYTES)));              // RL24 RL10 RL1
      usr_rdy_q <= !prio_busy_i && st_q == ST_IDLE && !msg_req_i &&
                   !buf_out_valid;                                        // RL9 RL13
    end
  end

  // Control ready follows buffer room, blocked by higher-ranked traffic
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ctl_rdy_q <= 1'b0;
    else
      ctl_rdy_q <= buf_in_ready && !prio_busy_i && st_q == ST_IDLE &&
                   !msg_req_i && !(ctl_take && buf_out_valid);            // RL19
  end

  // Buffer holds accepted control words until a lane slot is free
  sbm_skid #(
    .WIDTH ($bits(sbm_ctrl_t))
  ) u_ctl_buf (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (ctl_take),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_out_valid),
    .out_ready_i (!prio_busy_i && st_q == ST_IDLE),
    .out_data_o  (buf_out)
  );

  // Lane block selection: priority gap, message, control, none
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk_q   <= '0;
      blk_v_q <= 1'b0;
    end
    else
    begin
      blk_v_q     <= 1'b1;
      blk_q.block_type_field <= TYPE_CODE_BAD;
      blk_q.size  <= size_q;
      blk_q.data  <= 64'h0;
      // Ready is registered, so a word may be taken in the first busy cycle; it must still go out
      if (prio_busy_i && !msg_take)
      begin
        blk_q.kind <= SBM_BLK_IDLE;
        blk_v_q    <= 1'b0;
      end
      else if (st_q == ST_HDR)
        blk_q.kind <= SBM_BLK_MSG_HDR;                                    // RL11
      else if (st_q == ST_DATA)
      begin
        blk_q.kind <= msg_take ? SBM_BLK_MSG_DATA : SBM_BLK_IDLE;         // RL1
        blk_q.data <= msg_tx_data_i;                                      // RL25
      end
      else if (buf_out_valid)
      begin
        blk_q.kind <= SBM_BLK_CTRL;                                       // RL13 RL20
        blk_q.block_type_field <= buf_out.block_type_field;
        blk_q.data <= LITTLE_ENDIAN ? {8'h00, buf_out.word[63:8]}
                                    : {8'h00, buf_out.word[CTL_DAT_W-1:0]}; // RL18 RL22
      end
      else
      begin
        blk_q.kind <= SBM_BLK_USER;
        blk_v_q    <= 1'b0;
      end
    end
  end

  assign msg_tx_ready_o   = msg_rdy_q;
  assign usr_tx_ready_o   = usr_rdy_q;
  assign ctl_tx_ready_o   = ctl_rdy_q;
  assign lane_blk_o       = blk_q;
  assign lane_blk_valid_o = blk_v_q;

  logic        rx_v_q;
  logic [63:0] rx_d_q;
  logic        rx_l_q;
  logic [7:0]  rx_k_q;
  logic        rx_idle_n_q;
  logic        cr_v_q;
  logic [63:0] cr_d_q;
  logic [3:0]  rx_num;

  // Receive message path; keep filled from the top byte downward
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_v_q      <= 1'b0;
      rx_d_q      <= 64'h0;
      rx_l_q      <= 1'b0;
      rx_k_q      <= 8'h00;
      rx_idle_n_q <= 1'b1;
    end
    else
    begin
      rx_v_q <= rx_msg_valid_i;                                           // RL2
      rx_d_q <= rx_msg_data_i;
      rx_l_q <= rx_msg_valid_i && rx_msg_last_i;                          // RL3
      rx_k_q <= (rx_msg_valid_i && rx_msg_last_i)
                ? 8'(16'hFF00 >> rx_msg_nbytes_i) : 8'h00;                // RL4 RL12
      if (rx_msg_valid_i)
        rx_idle_n_q <= rx_msg_last_i;                                     // RL5
    end
  end

  assign rx_num = type2num(rx_ctl_i.block_type_field);

  // Receive control path: only the type code is translated
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cr_v_q <= 1'b0;
      cr_d_q <= 64'h0;
    end
    else
    begin
      cr_v_q <= rx_ctl_valid_i;                                           // RL21
      cr_d_q <= LITTLE_ENDIAN
                ? {rx_ctl_i.word[55:0], CTL_ZERO, rx_num}
                : {CTL_ZERO, rx_num, rx_ctl_i.word[55:0]};                // RL14 RL16
    end
  end

  assign msg_rx_valid_o  = rx_v_q;
  assign msg_rx_data_o   = rx_d_q;
  assign msg_rx_last_o   = rx_l_q;
  assign msg_rx_keep_o   = rx_k_q;
  assign msg_rx_idle_n_o = rx_idle_n_q;
  assign ctl_rx_valid_o  = cr_v_q;
  assign ctl_rx_data_o   = cr_d_q;

  // Checks
  chk_msg_rdy_lat: assert property (@(posedge mclk_i) disable iff (rst_i) // RL24
    (st_q == ST_IDLE && msg_req_i) ##1 !prio_busy_i[*2] |=> msg_rdy_q)
    else $error("message ready late");
  chk_hdr_gap: assert property (@(posedge mclk_i) disable iff (rst_i) // RL11
    $rose(msg_rdy_q) |-> !$past(usr_rdy_q))
    else $error("no header gap");
  chk_ready_excl: assert property (@(posedge mclk_i) disable iff (rst_i) // RL9
    msg_rdy_q |-> !usr_rdy_q && !ctl_rdy_q)
    else $error("two readies high");
  chk_prio_drop: assert property (@(posedge mclk_i) disable iff (rst_i) // RL10
    prio_busy_i |=> !msg_rdy_q && !ctl_rdy_q)
    else $error("ready under priority");
  chk_idle_ins: assert property (@(posedge mclk_i) disable iff (rst_i) // RL1
    (st_q == ST_DATA && msg_rdy_q && !msg_tx_valid_i && !prio_busy_i) |=>
    msg_rdy_q && blk_q.kind == SBM_BLK_IDLE)
    else $error("idle not inserted");
  chk_rx_keep: assert property (@(posedge mclk_i) disable iff (rst_i) // RL4
    !rx_l_q |-> rx_k_q == 8'h00)
    else $error("keep outside last");
  chk_rx_prog: assert property (@(posedge mclk_i) disable iff (rst_i) // RL5
    (rx_msg_valid_i && !rx_msg_last_i) |=> !msg_rx_idle_n_o)
    else $error("progress not low");
  chk_ctl_type: assert property (@(posedge mclk_i) disable iff (rst_i) // RL17
    (ctl_take && word_num(ctl_tx_data_i) == 4'h7) |-> buf_in.block_type_field == 8'h4B)
    else $error("bad type code");
  chk_take_sent: assert property (@(posedge mclk_i) disable iff (rst_i) // RL25
    msg_take |=> lane_blk_valid_o && blk_q.kind == SBM_BLK_MSG_DATA)
    else $error("taken word not sent");
  chk_ctl_sent: assert property (@(posedge mclk_i) disable iff (rst_i) // RL20
    (ctl_take && !buf_out_valid && !prio_busy_i && st_q == ST_IDLE) ##1
    (!prio_busy_i && st_q == ST_IDLE) |=> blk_q.kind == SBM_BLK_CTRL)
    else $error("control word lost");
  cov_msg: cover property (@(posedge mclk_i) msg_take && left_q > 9'd8);
  cov_ctl: cover property (@(posedge mclk_i) blk_q.kind == SBM_BLK_CTRL);
  cov_rx: cover property (@(posedge mclk_i) rx_l_q && rx_k_q == 8'hF0);
endmodule

// file: logic/sbm_skid.sv
// Two-entry buffer; ready upstream depends only on own occupancy
module sbm_skid
  import sbm_pkg::*;
#(
  parameter int unsigned WIDTH = 72
)
(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && (cnt_q != 2'd2);
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_q != 2'd2);
  assign out_valid_o = (cnt_q != 2'd0);
  assign out_data_o  = mem_q[rd_q];

  // Storage and pointers
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'd0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: sim/sbm_user_model.sv
// User application side of the message transmit path
module sbm_user_model
  import sbm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Commands from the bench
  input  wire logic        start_i,
  input  wire logic [7:0]  code_i,
  input  wire logic        stall_i,
  output logic             busy_o,
  // Message transmit toward the block
  output logic             msg_req_o,
  output logic [7:0]       size_o,
  output logic             valid_o,
  output logic [63:0]      data_o,
  input  wire logic        ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  int seq;
  bit pend;
  bit tog;

  // Everything changes on the falling edge; ready is stable then, so a take is known early
  always @(negedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o = 1'b0;
      msg_req_o = 1'b0;
      size_o = 8'h00;
      valid_o = 1'b0;
      data_o = 64'h0;
      left = 0;
      seq = 0;
      pend = 1'b0;
      tog = 1'b0;
    end
    else
    begin
      tog = !tog;
      msg_req_o = 1'b0;
      size_o = ~size_o;
      if (pend)
      begin
        left = left - 1;
        seq = seq + 1;
      end
      if (start_i && !busy_o)
      begin
        msg_req_o = 1'b1;
        size_o = code_i;
        left = int'(code_i) / 8 + 1;
        busy_o = 1'b1;
      end
      else if (busy_o && left == 0)
        busy_o = 1'b0;
      // Holes only when the bench asks for them, so idle insertion gets exercised
      valid_o = busy_o && !msg_req_o && left > 0 && !(stall_i && tog);
      data_o = valid_o ? {8{8'(seq + 8'h31)}} : ~data_o;
      pend = valid_o && ready_i;
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the sideband message and control block paths
module tb;
  import sbm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          mclk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          msg_req_i, msg_tx_valid_i, msg_tx_ready_o, usr_tx_ready_o, prio_busy_i = 1'b0;
  logic [7:0]    message_size_code_i;
  logic [63:0]   msg_tx_data_i, ctl_tx_data_i = 64'h0, rx_msg_data_i = 64'h0, msg_rx_data_o, ctl_rx_data_o;
  logic          ctl_tx_valid_i = 1'b0, ctl_tx_ready_o, lane_blk_valid_o, rx_ctl_valid_i = 1'b0;
  logic          rx_msg_valid_i = 1'b0, rx_msg_last_i = 1'b0, msg_rx_valid_o, msg_rx_last_o, msg_rx_idle_n_o;
  logic [3:0]    rx_msg_nbytes_i = 4'h0;
  logic [7:0]    msg_rx_keep_o;
  logic          ctl_rx_valid_o, start = 1'b0, stall = 1'b0, mdl_busy;
  logic [7:0]    code = 8'h00;
  sbm_lane_blk_t lane_blk_o;
  sbm_ctrl_t     rx_ctl_i = '0;
  int            fails = 0, compares = 0, cycles = 0, hdr_cnt = 0, dat_cnt = 0, tot_words = 0;
  logic [7:0]    type_q[$];
  logic [63:0]   ctl_dat_q[$], last_dat = 64'h0;
  logic [7:0]    last_size = 8'h00;
  logic [7:0]    type_tab [9] = '{TYPE_CODE_0, TYPE_CODE_1, TYPE_CODE_2, TYPE_CODE_3, TYPE_CODE_4,
                                  TYPE_CODE_5, TYPE_CODE_6, TYPE_CODE_7, TYPE_CODE_8};

  sbm_sideband #(.LITTLE_ENDIAN(1'b0)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .msg_req_i(msg_req_i),
    .message_size_code_i(message_size_code_i), .msg_tx_valid_i(msg_tx_valid_i), .msg_tx_data_i(msg_tx_data_i),
    .msg_tx_ready_o(msg_tx_ready_o), .usr_tx_ready_o(usr_tx_ready_o), .prio_busy_i(prio_busy_i),
    .ctl_tx_valid_i(ctl_tx_valid_i), .ctl_tx_data_i(ctl_tx_data_i), .ctl_tx_ready_o(ctl_tx_ready_o),
    .lane_blk_o(lane_blk_o), .lane_blk_valid_o(lane_blk_valid_o), .rx_msg_valid_i(rx_msg_valid_i),
    .rx_msg_data_i(rx_msg_data_i), .rx_msg_last_i(rx_msg_last_i), .rx_msg_nbytes_i(rx_msg_nbytes_i),
    .msg_rx_valid_o(msg_rx_valid_o), .msg_rx_data_o(msg_rx_data_o), .msg_rx_last_o(msg_rx_last_o),
    .msg_rx_keep_o(msg_rx_keep_o), .msg_rx_idle_n_o(msg_rx_idle_n_o), .rx_ctl_valid_i(rx_ctl_valid_i),
    .rx_ctl_i(rx_ctl_i), .ctl_rx_valid_o(ctl_rx_valid_o), .ctl_rx_data_o(ctl_rx_data_o));

  sbm_user_model i_user (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start), .code_i(code), .stall_i(stall),
    .busy_o(mdl_busy), .msg_req_o(msg_req_i), .size_o(message_size_code_i), .valid_o(msg_tx_valid_i),
    .data_o(msg_tx_data_i), .ready_i(msg_tx_ready_o));

  // Clock, plus a cycle ceiling so a stuck handshake cannot hang the run
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      close_out();
    end
  end
  // Tally blocks handed to the lanes by kind
  always @(posedge mclk_i)
  begin
    if (!rst_i && lane_blk_valid_o === 1'b1)
    begin
      if (lane_blk_o.kind === SBM_BLK_MSG_HDR) hdr_cnt++;
      if (lane_blk_o.kind === SBM_BLK_MSG_DATA)
      begin
        dat_cnt++;
        last_dat = lane_blk_o.data;
        last_size = lane_blk_o.size;
      end
      if (lane_blk_o.kind === SBM_BLK_CTRL)
      begin
        type_q.push_back(lane_blk_o.block_type_field);
        ctl_dat_q.push_back(lane_blk_o.data);
      end
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One message from request to final take; optional holes and a priority interruption
  task automatic tx_msg(input logic [7:0] c, input logic holes);
    int k;
    int words;
    words = int'(c) / 8 + 1;
    hdr_cnt = 0;
    dat_cnt = 0;
    stall = holes;
    @(negedge mclk_i) code = c;
    start <= 1'b1;
    @(negedge mclk_i) start <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk_bit(msg_tx_ready_o | usr_tx_ready_o, 1'b0);
    @(negedge mclk_i) #1;
    chk_bit(msg_tx_ready_o, 1'b1);
    chk_bit(usr_tx_ready_o, 1'b0);
    chk_bit(ctl_tx_ready_o, 1'b0);
    if (holes)
    begin
      prio_busy_i = 1'b1;
      @(negedge mclk_i) chk_bit(msg_tx_ready_o, 1'b0);
      prio_busy_i = 1'b0;
      repeat (2) @(negedge mclk_i);
    end
    for (k = 0; k < 60 && mdl_busy; k++)
    begin
      @(negedge mclk_i) #1;
      if (mdl_busy && !msg_tx_valid_i) chk_bit(msg_tx_ready_o, 1'b1);
    end
    @(negedge mclk_i) chk_bit(msg_tx_ready_o, 1'b0);
    repeat (3) @(negedge mclk_i);
    chk_word(64'(hdr_cnt), 64'h1);
    chk_word(64'(dat_cnt), 64'(words));
    chk_word(last_dat, {8{8'(tot_words + words + 8'h30)}});
    chk_word(64'(last_size), 64'(c));
    tot_words += words;
    stall = 1'b0;
  endtask

  // All nine block numbers back to back, after a refused cycle
  task automatic tx_ctl();
    int k;
    type_q.delete();
    ctl_dat_q.delete();
    @(negedge mclk_i) prio_busy_i = 1'b1;
    @(negedge mclk_i) chk_bit(ctl_tx_ready_o, 1'b0);
    prio_busy_i = 1'b0;
    for (int n = 0; n <= CTL_NUM_MAX; n++)
    begin
      ctl_tx_data_i = {CTL_ZERO, 4'(n), 56'hC0DE_0000_0000_00 | 56'(n)};
      ctl_tx_valid_i = 1'b1;
      for (k = 0; k < 20 && ctl_tx_ready_o !== 1'b1; k++) @(negedge mclk_i);
      @(negedge mclk_i);
    end
    ctl_tx_valid_i = 1'b0;
    ctl_tx_data_i = ~ctl_tx_data_i;
    repeat (6) @(negedge mclk_i);
    chk_word(64'(type_q.size()), 64'h9);
    for (int n = 0; n < type_q.size() && n <= CTL_NUM_MAX; n++)
    begin
      chk_word(64'(type_q[n]), 64'(type_tab[n]));
      chk_word(ctl_dat_q[n], {8'h00, 56'hC0DE_0000_0000_00 | 56'(n)});
    end
  endtask

  // One received message word; outputs follow one cycle later
  task automatic rx_word(input logic [63:0] d, input logic last, input logic [3:0] nb);
    rx_msg_valid_i = 1'b1;
    rx_msg_data_i = d;
    rx_msg_last_i = last;
    rx_msg_nbytes_i = nb;
    @(negedge mclk_i) chk_bit(msg_rx_valid_o, 1'b1);
    chk_word(msg_rx_data_o, d);
    chk_bit(msg_rx_last_o, last);
    if (last) chk_word(64'(msg_rx_keep_o), 64'(8'(8'hFF << (8 - nb))));
    else chk_bit(msg_rx_idle_n_o, 1'b0);
  endtask

  task automatic rx_idle();
    rx_msg_valid_i = 1'b0;
    rx_msg_last_i = 1'b0;
    rx_msg_data_i = ~rx_msg_data_i;
    repeat (2) @(negedge mclk_i);
    chk_bit(msg_rx_valid_o, 1'b0);
    chk_bit(msg_rx_idle_n_o, 1'b1);
  endtask

  // Every type code back to back, decoded into the block number
  task automatic rx_ctl();
    for (int n = 0; n <= CTL_NUM_MAX; n++)
    begin
      rx_ctl_valid_i = 1'b1;
      rx_ctl_i = '{block_type_field: type_tab[n], word: {8'h00, 56'h5A_1234_0000_0000 | 56'(n)}};
      @(negedge mclk_i) chk_bit(ctl_rx_valid_o, 1'b1);
      chk_word(ctl_rx_data_o, {CTL_ZERO, 4'(n), 56'h5A_1234_0000_0000 | 56'(n)});
    end
    // A code outside the table decodes to the spare block number
    rx_ctl_i = '{block_type_field: TYPE_CODE_BAD, word: 64'h0};
    @(negedge mclk_i) chk_word(ctl_rx_data_o, {CTL_ZERO, 4'hF, 56'h0});
    rx_ctl_valid_i = 1'b0;
    rx_ctl_i = ~rx_ctl_i;
    @(negedge mclk_i) chk_bit(ctl_rx_valid_o, 1'b0);
  endtask

  task automatic close_out();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge mclk_i);
    chk_bit(msg_tx_ready_o | ctl_tx_ready_o | msg_rx_valid_o, 1'b0);
    chk_bit(msg_rx_idle_n_o, 1'b1);
    rst_i = 1'b0;
    tx_msg(8'h03, 1'b0);
    tx_msg(8'h0F, 1'b1);
    tx_msg(8'hFF, 1'b0);
    tx_ctl();
    rx_word(64'hA1B2_C3D4_0000_0000, 1'b1, 4'h4);
    rx_idle();
    rx_word(64'h1122_3344_5566_7788, 1'b0, 4'h8);
    rx_word(64'h99AA_BBCC_DDEE_FF00, 1'b1, 4'h7);
    rx_idle();
    rx_word(64'h0102_0304_0506_0708, 1'b1, 4'h8);
    rx_idle();
    rx_ctl();
    close_out();
  end
endmodule
